// ===== core/icr_ctrl.v
// Interrupt control and status registers with priority resolution
//
// Behaviour
// RULE1: Each source has a flag set by hardware, cleared only by software.
// RULE2: Each source has its own software enable bit.
// RULE3: Each source has a 3-bit software priority, eight levels.
// RULE4: Capture latches 7-bit vector number and 4-bit pending level.
// RULE5: Source n uses flag bit n, enable bit n, priority bits 3n+2:3n.
// RULE6: CPU level held in status bits 7-5, software writable; bit 3 extends.
// RULE7: Level bits 111 mean level 7, no user interrupt taken.
// RULE8: Core level bit 3 set means level 8-15, user interrupts off.
// RULE9: Core level bit 3 is not software writable.
// RULE10: Control one bit 15 set disables nesting, clear enables it.
// RULE11: With nesting disabled the status level bits ignore writes.
// RULE12: Control one holds accumulator overflow and catastrophic trap flags.
// RULE13: Control one bits 3,2,1 flag address, stack, oscillator traps.
// RULE14: Control one bit 7 flags an invalid accumulator shift trap.
// RULE15: Control two bit 15 selects alternate table; bit 14 shows disable.
// RULE16: Control two bits 4:0 pick falling edge when 1, rising when 0.
// RULE17: Unimplemented bits ignore writes and read as zero.
// RULE18: Alternate select makes every vector come from alternate table.
// RULE19: Present highest enabled pending above CPU level; ties to lowest.
// RULE20: Every flag, enable and priority field clears on reset.
`timescale 1ns/100ps
`default_nettype none
`include "icr_regs.vh"

module icr_ctrl #(
    parameter NUM_SRC = 16,
    parameter NUM_EXT = 5
) (
    // Clock and reset
    input  wire                 clk_sys,
    input  wire                 reset,
    // Wishbone slave
    input  wire                 wb_cyc_i,
    input  wire                 wb_stb_i,
    input  wire                 wb_we_i,
    input  wire [7:0]           wb_adr_i,
    input  wire [3:0]           wb_sel_i,
    input  wire [31:0]          wb_dat_i,
    output reg  [31:0]          wb_dat_o,
    output reg                  wb_ack_o,
    // Peripheral request pulses, bit n is source n
    input  wire [NUM_SRC-1:0]   srcReq,
    // External interrupt pins
    input  wire [NUM_EXT-1:0]   extIrqPin,
    // Trap causes, one-cycle pulses
    input  wire                 trapAccAOvf,
    input  wire                 trapAccBOvf,
    input  wire                 trapAccACat,
    input  wire                 trapAccBCat,
    input  wire                 trapShiftErr,
    input  wire                 trapAddress,
    input  wire                 trapStack,
    input  wire                 trapOscFail,
    // Core side
    input  wire                 coreLevel3Set,
    input  wire                 coreLevel3Clr,
    input  wire                 disableInstrActive,
    output reg                  irqValid,
    output reg  [6:0]           irqVector,
    output reg  [3:0]           irqLevel,
    output wire                 altVectorSelect
);

    // ==========================================================
    // Registers
    reg  [2:0]          cpuLevel_reg;
    reg                 cpuLevel3_reg;
    reg  [15:0]         ctlOne_reg;
    reg  [15:0]         ctlTwo_reg;
    reg  [NUM_SRC-1:0]  flag_reg;
    reg  [NUM_SRC-1:0]  enable_reg;
    reg  [3*NUM_SRC-1:0] prio_reg;
    reg  [6:0]          capVector_reg;
    reg  [3:0]          capLevel_reg;
    reg  [NUM_EXT-1:0]  sync1_reg;
    reg  [NUM_EXT-1:0]  sync2_reg;
    reg  [NUM_EXT-1:0]  sync3_reg;

    // A request is taken at one edge only: the ack it raises gates a
    // second take while the master still holds cyc and stb
    wire                access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire                wrLo = access & wb_we_i & wb_sel_i[0];
    wire                wrHi = access & wb_we_i & wb_sel_i[1];
    wire [15:0]         wd = wb_dat_i[15:0];

    // ==========================================================
    // External pin edge detection
    // A pin level is accepted only when stages two and three agree, so
    // a one-cycle glitch that slips through the first stage is dropped.
    // The edge is taken against the accepted level, not a raw stage, so
    // a polarity change while the pin sits still never fakes an edge.
    wire [NUM_EXT-1:0]  extEdge;
    wire [NUM_EXT-1:0]  pinAgree;
    wire [NUM_EXT-1:0]  pinLevel_next;
    reg  [NUM_EXT-1:0]  pinLevel_reg;
    wire [NUM_SRC-1:0]  hwSet;
    genvar g;
    generate
        for (g = 0; g < NUM_EXT; g = g + 1) begin : gExt
            // Stages two and three hold the same value
            assign pinAgree[g] = ~(sync2_reg[g] ^ sync3_reg[g]);
            // Accepted level follows stage three only on agreement
            assign pinLevel_next[g] = pinAgree[g] ? sync3_reg[g] :
                                                    pinLevel_reg[g];
            // Falling when polarity is 1, rising when 0
            assign extEdge[g] = pinAgree[g] &
                (sync3_reg[g] != pinLevel_reg[g]) &
                (sync3_reg[g] ^ ctlTwo_reg[g]); // see RULE16
        end
    endgenerate

    // External pin n raises source n; sources above the pins come
    // from peripheral request lines only
    assign hwSet = srcReq |
        {{(NUM_SRC-NUM_EXT){1'b0}}, extEdge};

    // Three-stage pin synchroniser and accepted pin level. The level
    // clears low on reset, so a pin that rests high shows one rising
    // edge after reset; software clears that flag before enabling it.
    always @(posedge clk_sys) begin
        if (reset) begin
            sync1_reg <= {NUM_EXT{1'b0}};
            sync2_reg <= {NUM_EXT{1'b0}};
            sync3_reg <= {NUM_EXT{1'b0}};
            pinLevel_reg <= {NUM_EXT{1'b0}};
        end else begin
            sync1_reg <= extIrqPin;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pinLevel_reg <= pinLevel_next;
        end
    end

    // ==========================================================
    // Write byte-lane merge helpers. Lanes are gated by the take, so a
    // held request or an idle bus leaves every register as it was; the
    // mask keeps read-only and unused bits out of every write.
    function [15:0] merge;
        input [15:0] old;
        input [15:0] mask;
        reg   [15:0] lane;
        begin
            lane = {{8{wrHi}}, {8{wrLo}}} & mask;
            merge = (old & ~lane) | (wd & lane);
        end
    endfunction

    // ==========================================================
    // Control and status registers
    // Trap causes gathered at their flag positions in control one
    reg  [15:0] trapSet;
    always @* begin
        trapSet = `ICR_RST_WORD;
        trapSet[`ICR_OVA_BIT]  = trapAccAOvf;  // see RULE12
        trapSet[`ICR_OVB_BIT]  = trapAccBOvf;  // see RULE12
        trapSet[`ICR_COVA_BIT] = trapAccACat;  // see RULE12
        trapSet[`ICR_COVB_BIT] = trapAccBCat;  // see RULE12
        trapSet[`ICR_SFT_BIT]  = trapShiftErr; // see RULE14
        trapSet[`ICR_ADDR_BIT] = trapAddress;  // see RULE13
        trapSet[`ICR_STK_BIT]  = trapStack;    // see RULE13
        trapSet[`ICR_OSC_BIT]  = trapOscFail;  // see RULE13
    end

    wire [15:0] statusWr = merge({8'h00, cpuLevel_reg, 5'h00},
                                 `ICR_MASK_STATUS);

    always @(posedge clk_sys) begin
        if (reset) begin // see RULE20
            cpuLevel_reg  <= 3'h0;
            cpuLevel3_reg <= 1'b0;
            ctlOne_reg    <= `ICR_RST_WORD;
            ctlTwo_reg    <= `ICR_RST_WORD;
        end else begin
            // Level bits locked while nesting is off
            if (wb_adr_i == `ICR_OFS_STATUS &&
                !ctlOne_reg[`ICR_NEST_BIT]) // see RULE11
                cpuLevel_reg <=
                    statusWr[`ICR_LVL_HI:`ICR_LVL_LO]; // see RULE6
            // Bit 3 moves only by core, never by bus; a set and a clear
            // in one cycle leave it set, the safer of the two
            if (coreLevel3Set)
                cpuLevel3_reg <= 1'b1; // see RULE9
            else if (coreLevel3Clr)
                cpuLevel3_reg <= 1'b0;
            // Trap flags: set wins over a clearing write
            if (wb_adr_i == `ICR_OFS_CTL1)
                ctlOne_reg <= merge(ctlOne_reg, `ICR_MASK_CTL1) |
                    trapSet; // see RULE10
            else
                ctlOne_reg <= ctlOne_reg | trapSet;
            if (wb_adr_i == `ICR_OFS_CTL2)
                ctlTwo_reg <= merge(ctlTwo_reg,
                    `ICR_MASK_CTL2); // see RULE17
        end
    end

    // ==========================================================
    // Flags, enables and priorities
    always @(posedge clk_sys) begin
        if (reset) begin // see RULE20
            flag_reg   <= {NUM_SRC{1'b0}};
            enable_reg <= {NUM_SRC{1'b0}};
            prio_reg   <= {(3*NUM_SRC){1'b0}};
        end else begin
            // Hardware set beats a software clear: a request arriving in
            // the cycle of a clearing write is kept, never lost
            if (wb_adr_i == `ICR_OFS_FLAGS)
                flag_reg <= merge(flag_reg, 16'hFFFF) |
                    hwSet; // see RULE1
            else
                flag_reg <= flag_reg | hwSet; // see RULE1
            if (wb_adr_i == `ICR_OFS_ENABLE)
                enable_reg <= merge(enable_reg, 16'hFFFF); // see RULE2
            // Four sources per priority word, bit 3 of each nibble zero;
            // the four words cover the sixteen default sources
            if (wb_adr_i == `ICR_OFS_PRIO0)
                prio_reg[11:0] <= pack(merge(unpack(prio_reg[11:0]),
                    16'h7777)); // see RULE3
            if (wb_adr_i == `ICR_OFS_PRIO1)
                prio_reg[23:12] <= pack(merge(unpack(prio_reg[23:12]),
                    16'h7777)); // see RULE5
            if (wb_adr_i == `ICR_OFS_PRIO2)
                prio_reg[35:24] <= pack(merge(unpack(prio_reg[35:24]),
                    16'h7777));
            if (wb_adr_i == `ICR_OFS_PRIO3)
                prio_reg[47:36] <= pack(merge(unpack(prio_reg[47:36]),
                    16'h7777));
        end
    end

    // Nibble packing of priority fields
    function [15:0] unpack;
        input [11:0] p;
        begin
            unpack = {1'b0, p[11:9], 1'b0, p[8:6],
                      1'b0, p[5:3], 1'b0, p[2:0]};
        end
    endfunction

    function [11:0] pack;
        input [15:0] w;
        begin
            pack = {w[14:12], w[10:8], w[6:4], w[2:0]};
        end
    endfunction

    // ==========================================================
    // Priority resolution
    reg  [2:0]  bestPrio;
    reg  [6:0]  bestIdx;
    reg         bestHit;
    reg  [2:0]  thisPrio;
    integer     i;
    always @* begin
        bestPrio = 3'h0;
        bestIdx  = 7'h00;
        bestHit  = 1'b0;
        thisPrio = 3'h0;
        // Strictly greater keeps the lowest index on ties: the scan runs
        // from source zero upward, so an equal priority met later never
        // displaces the earlier source
        for (i = 0; i < NUM_SRC; i = i + 1) begin
            thisPrio = prio_reg[3*i +: 3];
            if (flag_reg[i] && enable_reg[i] &&
                (!bestHit || thisPrio > bestPrio)) begin // see RULE19
                bestPrio = thisPrio;
                bestIdx  = i[6:0];
                bestHit  = 1'b1;
            end
        end
    end

    // Level 7 or bit 3 set blocks every user source. Bit 3 comes only
    // from the core, so software cannot mask a trap by writing a
    // level; the pending request must also beat the current level.
    wire above = bestHit && !cpuLevel3_reg && // see RULE8
                 cpuLevel_reg != `ICR_LVL_MAX && // see RULE7
                 bestPrio > cpuLevel_reg; // see RULE19

    always @(posedge clk_sys) begin
        if (reset) begin
            capVector_reg <= 7'h00;
            capLevel_reg  <= `ICR_RST_LEVEL;
            irqValid      <= 1'b0;
            irqVector     <= 7'h00;
            irqLevel      <= `ICR_RST_LEVEL;
        end else begin
            // Valid follows the qualified request every cycle; vector,
            // level and capture hold their last value while it is low
            irqValid <= above;
            if (above) begin
                capVector_reg <= bestIdx + `ICR_VEC_BASE; // see RULE4
                capLevel_reg  <= {1'b0, bestPrio}; // see RULE4
                irqVector     <= bestIdx + `ICR_VEC_BASE;
                irqLevel      <= {1'b0, bestPrio};
            end
        end
    end

    // Vector fetch steered to alternate table; the core reads this
    // level at each vector fetch, traps included
    assign altVectorSelect = ctlTwo_reg[`ICR_ALT_BIT]; // see RULE18

    // ==========================================================
    // Bus read and acknowledge
    reg  [15:0] rd;
    always @* begin
        rd = `ICR_RST_WORD;
        case (wb_adr_i)
            `ICR_OFS_STATUS:  rd = {8'h00, cpuLevel_reg, 5'h00};
            `ICR_OFS_CORE:    rd = {12'h000, cpuLevel3_reg, 3'h0};
            `ICR_OFS_CTL1:    rd = ctlOne_reg;
            `ICR_OFS_CTL2:    rd = {ctlTwo_reg[15], disableInstrActive,
                                    ctlTwo_reg[13:0]}; // see RULE15
            `ICR_OFS_FLAGS:   rd = flag_reg;
            `ICR_OFS_ENABLE:  rd = enable_reg;
            `ICR_OFS_PRIO0:   rd = unpack(prio_reg[11:0]);
            `ICR_OFS_PRIO1:   rd = unpack(prio_reg[23:12]);
            `ICR_OFS_PRIO2:   rd = unpack(prio_reg[35:24]);
            `ICR_OFS_PRIO3:   rd = unpack(prio_reg[47:36]);
            // Level sits in bits 11:8, vector in bits 6:0
            `ICR_OFS_CAPTURE: rd = {4'h0, capLevel_reg, 1'b0,
                                    capVector_reg}; // see RULE4
            default:          rd = `ICR_RST_WORD; // see RULE17
        endcase
    end

    // One-cycle ack, data registered with it; the answer comes one
    // cycle after the take and drops in the cycle after that
    always @(posedge clk_sys) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= access;
            wb_dat_o <= {16'h0000, rd};
        end
    end

endmodule // icr_ctrl
`default_nettype wire

// ===== core/icr_regs.vh
// Register offsets, field positions and reset values of the interrupt block
`ifndef ICR_REGS_VH
`define ICR_REGS_VH
// Byte offsets on the register bus
`define ICR_OFS_STATUS  8'h00
`define ICR_OFS_CORE    8'h04
`define ICR_OFS_CTL1    8'h08
`define ICR_OFS_CTL2    8'h0C
`define ICR_OFS_FLAGS   8'h10
`define ICR_OFS_ENABLE  8'h14
`define ICR_OFS_PRIO0   8'h18
`define ICR_OFS_PRIO1   8'h1C
`define ICR_OFS_PRIO2   8'h20
`define ICR_OFS_PRIO3   8'h24
`define ICR_OFS_CAPTURE 8'h28
// Field positions
`define ICR_LVL_LO      5
`define ICR_LVL_HI      7
`define ICR_LVL3_BIT    3
`define ICR_NEST_BIT    15
`define ICR_OVA_BIT     14
`define ICR_OVB_BIT     13
`define ICR_COVA_BIT    12
`define ICR_COVB_BIT    11
`define ICR_SFT_BIT     7
`define ICR_ADDR_BIT    3
`define ICR_STK_BIT     2
`define ICR_OSC_BIT     1
`define ICR_ALT_BIT     15
`define ICR_DISABLE_INSTR_ACTIVE_BIT    14
// Writable masks of the status and control registers
`define ICR_MASK_STATUS 16'h00E0
`define ICR_MASK_CTL1   16'hF88E
`define ICR_MASK_CTL2   16'h801F
// Reset values and the top CPU level
`define ICR_RST_WORD    16'h0000
`define ICR_RST_LEVEL   4'h0
`define ICR_LVL_MAX     3'h7
// Vector number of source zero
`define ICR_VEC_BASE    7'h08
`endif

// ===== tb/icr_ctrl_sva.sv
// Port assertions for the interrupt register block
`timescale 1ns/100ps
`default_nettype none
`include "icr_regs.vh"
module icr_ctrl_sva #(parameter NUM_SRC = 16) (
    // Clock, reset and bus
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Core side
    input wire logic        coreLevel3Set,
    input wire logic        irqValid,
    input wire logic [6:0]  irqVector,
    input wire logic [3:0]  irqLevel,
    input wire logic        altVectorSelect
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Request taken at this edge
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // ==========================================
    // Bus answer
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_after_take_a: assert property (take |=> wb_ack_o)
        else $error("ack missing after request");
    upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    // ==========================================
    // Core request
    vector_range_a: assert property (irqValid |->
        irqVector >= `ICR_VEC_BASE && irqVector < `ICR_VEC_BASE + NUM_SRC)
        else $error("vector outside source range");
    level_range_a: assert property (irqValid |->
        irqLevel != 4'h0 && irqLevel <= 4'h7)
        else $error("request level cannot beat cpu level");
    trap_block_a: assert property (coreLevel3Set |-> ##2 !irqValid)
        else $error("request shown above level seven");
    vector_hold_a: assert property (!irqValid ##1 !irqValid
        |-> $stable(irqVector))
        else $error("vector moved while idle");
    reset_clear_a: assert property ($fell(reset) |-> !irqValid
        && irqLevel == 4'h0 && !altVectorSelect)
        else $error("outputs not cleared by reset");
    alt_follow_a: assert property (take && wb_we_i && wb_sel_i[1]
        && wb_adr_i == `ICR_OFS_CTL2 |=> altVectorSelect == $past(wb_dat_i[15]))
        else $error("alternate select did not follow write");
    // Main scenarios
    cover property (take && !wb_we_i);
    cover property ($rose(irqValid));
    cover property ($rose(altVectorSelect));
endmodule // icr_ctrl_sva
bind icr_ctrl icr_ctrl_sva #(.NUM_SRC(NUM_SRC)) u_icr_ctrl_sva (.clk_sys,
    .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .coreLevel3Set, .irqValid, .irqVector, .irqLevel,
    .altVectorSelect);
`default_nettype wire

// ===== tb/icr_ctrl_tb.sv
// Self-checking bench for the interrupt register block
`timescale 1ns/100ps
`default_nettype none
`include "icr_regs.vh"
module icr_ctrl_tb;
    logic        clk_sys, reset, cyc, stb, we, ack, lvlSet, lvlClr, disable_instr_active;
    logic        valid, alt;
    logic [7:0]  adr, trap;
    logic [3:0]  sel, lvl, lanes;
    logic [31:0] wdat, rdatW;
    logic [15:0] fire, req, rdat;
    logic [4:0]  pin;
    logic [6:0]  vec;
    int          errorCnt, nChecks, cycles, i;
    int          pos [8] = '{1, 2, 3, 7, 11, 12, 13, 14};

    icr_src_model u_icr_src_model (.clk_sys(clk_sys), .fire(fire),
        .srcReq(req));
    icr_ctrl u_icr_ctrl (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdatW), .wb_ack_o(ack), .srcReq(req),
        .extIrqPin(pin), .trapAccAOvf(trap[7]), .trapAccBOvf(trap[6]),
        .trapAccACat(trap[5]), .trapAccBCat(trap[4]),
        .trapShiftErr(trap[3]), .trapAddress(trap[2]), .trapStack(trap[1]),
        .trapOscFail(trap[0]), .coreLevel3Set(lvlSet),
        .coreLevel3Clr(lvlClr), .disableInstrActive(disable_instr_active),
        .irqValid(valid), .irqVector(vec), .irqLevel(lvl),
        .altVectorSelect(alt));

    // ==========================================
    // Bus and comparison tasks
    task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, lanes, 16'h0000, d};
        // Request held until ack is sampled high at a rising edge
        do @(posedge clk_sys); while (ack !== 1'b1);
        rdat = rdatW[15:0];
        {cyc, stb} <= 2'b00;
    endtask
    task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        nChecks++;
        if (s !== e) begin
            errorCnt++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task rc(input logic [7:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        chk($sformatf("register %h", a), rdat, e);
    endtask
    // Request to the core: valid, level, vector
    task irq(input logic [11:0] e);
        repeat (4) @(negedge clk_sys);
        chk("core request", {4'h0, valid, valid ? {lvl, vec} : 11'h000},
            {4'h0, e});
    endtask
    task src(input int n);
        @(posedge clk_sys);
        fire <= 16'h0001 << n;
        @(posedge clk_sys);
        fire <= 16'h0000;
    endtask
    task core(input logic [1:0] sc);
        @(posedge clk_sys);
        {lvlSet, lvlClr} <= sc;
        @(posedge clk_sys);
        {lvlSet, lvlClr} <= 2'b00;
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================
    // Clock and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errorCnt++;
            finish_test;
        end
    end

    // ==========================================
    // Test sequence
    initial begin
        reset = 1'b1;
        {cyc, stb, we, adr, sel, wdat, fire, pin, trap} = '0;
        {lvlSet, lvlClr, disable_instr_active} = 3'h0;
        lanes = 4'h3;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        for (i = 0; i < 12; i++) rc(8'(4 * i), 16'h0000);
        $display("test reset done");
        bus(1'b1, `ICR_OFS_CORE, 16'hFFFF);
        rc(`ICR_OFS_CORE, 16'h0000);
        bus(1'b1, `ICR_OFS_STATUS, 16'hFFFF);
        rc(`ICR_OFS_STATUS, 16'h00E0);
        bus(1'b1, `ICR_OFS_CTL2, 16'hFFFF);
        disable_instr_active <= 1'b1;
        rc(`ICR_OFS_CTL2, 16'hC01F);
        chk("alt select", {15'h0000, alt}, 16'h0001);
        bus(1'b1, `ICR_OFS_CTL2, 16'h0000);
        bus(1'b1, `ICR_OFS_CTL1, 16'hFFFF);
        rc(`ICR_OFS_CTL1, 16'hF88E);
        bus(1'b1, `ICR_OFS_STATUS, 16'h0000);
        rc(`ICR_OFS_STATUS, 16'h00E0);
        bus(1'b1, `ICR_OFS_CTL1, 16'h0000);
        bus(1'b1, `ICR_OFS_STATUS, 16'h0000);
        rc(`ICR_OFS_STATUS, 16'h0000);
        $display("test masks done");
        for (i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            trap <= 8'h01 << i;
            @(posedge clk_sys);
            trap <= 8'h00;
            rc(`ICR_OFS_CTL1, 16'h0001 << pos[i]);
            bus(1'b1, `ICR_OFS_CTL1, 16'h0000);
        end
        for (i = 0; i < 16; i += 5) begin
            src(i);
            rc(`ICR_OFS_FLAGS, 16'h0001 << i);
            bus(1'b1, `ICR_OFS_FLAGS, 16'h0000);
            rc(`ICR_OFS_FLAGS, 16'h0000);
        end
        $display("test flags done");
        // Source 3 at priority 4, source 5 at priority 6
        bus(1'b1, `ICR_OFS_PRIO0, 16'h4000);
        bus(1'b1, `ICR_OFS_PRIO1, 16'h0060);
        rc(`ICR_OFS_PRIO1, 16'h0060);
        src(3);
        src(5);
        irq(12'h000);
        bus(1'b1, `ICR_OFS_ENABLE, 16'h0028);
        irq({1'b1, 4'h6, 7'h0D});
        rc(`ICR_OFS_CAPTURE, 16'h060D);
        bus(1'b1, `ICR_OFS_STATUS, 16'h00C0);
        irq(12'h000);
        bus(1'b1, `ICR_OFS_STATUS, 16'h0060);
        irq({1'b1, 4'h6, 7'h0D});
        bus(1'b1, `ICR_OFS_PRIO0, 16'h6000);
        irq({1'b1, 4'h6, 7'h0B});
        bus(1'b1, `ICR_OFS_PRIO0, 16'h7000);
        bus(1'b1, `ICR_OFS_STATUS, 16'h00E0);
        irq(12'h000);
        bus(1'b1, `ICR_OFS_STATUS, 16'h0000);
        irq({1'b1, 4'h7, 7'h0B});
        core(2'b10);
        irq(12'h000);
        rc(`ICR_OFS_CORE, 16'h0008);
        core(2'b01);
        irq({1'b1, 4'h7, 7'h0B});
        $display("test priority done");
        bus(1'b1, `ICR_OFS_ENABLE, 16'h0000);
        bus(1'b1, `ICR_OFS_FLAGS, 16'h0000);
        // Low byte lane only: the high byte keeps its old value
        lanes = 4'h1;
        bus(1'b1, `ICR_OFS_ENABLE, 16'hFFFF);
        lanes = 4'h3;
        rc(`ICR_OFS_ENABLE, 16'h00FF);
        bus(1'b1, `ICR_OFS_ENABLE, 16'h0000);
        for (i = 0; i < 5; i++) begin
            pin[i] <= 1'b1;
            repeat (8) @(posedge clk_sys);
            rc(`ICR_OFS_FLAGS, 16'h0001 << i);
            bus(1'b1, `ICR_OFS_CTL2, 16'h0001 << i);
            bus(1'b1, `ICR_OFS_FLAGS, 16'h0000);
            pin[i] <= 1'b0;
            repeat (8) @(posedge clk_sys);
            rc(`ICR_OFS_FLAGS, 16'h0001 << i);
            bus(1'b1, `ICR_OFS_FLAGS, 16'h0000);
        end
        // A pin pulse one cycle long is filtered out
        pin[0] <= 1'b1;
        @(posedge clk_sys);
        pin[0] <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rc(`ICR_OFS_FLAGS, 16'h0000);
        $display("test edges done");
        finish_test;
    end
endmodule // icr_ctrl_tb
`default_nettype wire

// ===== tb/icr_src_model.sv
// Peripheral side model turning bench commands into request pulses
`timescale 1ns/100ps
`default_nettype none
module icr_src_model (
    // Clock and command
    input  wire logic        clk_sys,
    input  wire logic [15:0] fire,
    // Request pulses into the block
    output var  logic [15:0] srcReq
);
    // Each commanded source raises its request for one cycle
    always @(posedge clk_sys) begin
        srcReq <= fire;
    end
endmodule // icr_src_model
`default_nettype wire
